// file: pfm_map.svh
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH
// Port data (write: output latch, read: pin or latch)
`define PFM_OFS_DAT_A    8'h00
`define PFM_OFS_DAT_B    8'h01
`define PFM_OFS_DAT_S    8'h02
`define PFM_OFS_DAT_K    8'h04
`define PFM_OFS_DAT_T    8'h06
`define PFM_OFS_DAT_L    8'h08
// Direction, bit = 1 selects input
`define PFM_OFS_DIR_A    8'h20
`define PFM_OFS_DIR_B    8'h21
`define PFM_OFS_DIR_S    8'h22
`define PFM_OFS_DIR_K    8'h24
`define PFM_OFS_DIR_T    8'h26
`define PFM_OFS_DIR_L    8'h28
// Pull-up and function selection
`define PFM_OFS_PU_SH    8'h30
`define PFM_OFS_PU_SER   8'h32
`define PFM_OFS_KRM      8'h34
`define PFM_OFS_LCD_SEL  8'h38
`define PFM_OFS_SER_CTL  8'h3a
`define PFM_OFS_KEY_CTL  8'h3c
`define PFM_OFS_TMR_CTL  8'h3e
`define PFM_OFS_EDGE     8'h40
// Event status, enable, clear
`define PFM_OFS_STAT     8'h44
`define PFM_OFS_IEN      8'h45
`define PFM_OFS_ICLR     8'h46
// Field positions
`define PFM_PU_SH_A      0
`define PFM_PU_SH_B      1
`define PFM_PU_SH_K      4
`define PFM_EDGE_RISE    0
`define PFM_EDGE_FALL    1
`define PFM_EVT_INT      0
`define PFM_EVT_KEY      1
// Reset values
`define PFM_RST_ZERO     8'h00
`define PFM_RST_DIR      8'hff
`endif

// file: pfm_pkg.sv
package pfm_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pfm_bus_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } pfm_drv_t;

    typedef struct packed {
        logic [3:0] a;
        logic [1:0] b;
        logic [2:0] s;
        logic [3:0] k;
        logic [1:0] t;
        logic [5:0] l;
    } pfm_pins_t;

    typedef struct packed {
        pfm_pins_t  lat;
        pfm_pins_t  dir;
        logic [7:0] pu_sh;
        logic [2:0] pu_ser;
        logic       krm;
        logic [5:0] lcd_sel;
        logic [2:0] ser_ctl;
        logic [3:0] key_ctl;
        logic [1:0] tmr_ctl;
        logic [1:0] edge_sel;
        logic [1:0] ien;
    } pfm_cfg_t;
endpackage

// file: pfm_port_mux.sv
// Operation
// [R1] Group A four pins, each direction from its own direction bit.
// [R2] Group B two pins, each direction from its own direction bit.
// [R3] Shared pull-up option enables groups A/B per port, input pins only.
// [R4] Serial group: per-pin direction and per-pin dedicated pull-up enable.
// [R5] Serial control mode per bit: clock, data out, data in replace port.
// [R6] Serial pins still obey direction bit and output latch value.
// [R7] Key group per-pin direction; pull-up from shared option or key-return mode.
// [R8] Key control mode pins feed key-return event detection.
// [R9] Timer/interrupt group two pins, per-pin direction.
// [R10] Control mode: pin 0 drives timer output, pin 1 is interrupt input.
// [R11] Interrupt input edge selectable: rising, falling, or both.
// [R12] LCD group function select per pin: port or segment output.
// [R13] LCD group in port mode follows its own direction bits.
// [R14] Active-low reset clears all logic and port configuration; the code loads the direction bits with 1 (input) instead of clearing them.
// [R15] External clock source drives main_osc_in and inverse on main_osc_inv.
// [R16] After reset all pins input, port function, pull-ups off.
// [R17] Output pin drives latch; input read returns sampled pin level.
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "pfm_map.svh"
module pfm_port_mux (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire pfm_pkg::pfm_bus_req_t bus,
    output logic [7:0]                 rdata,
    input  wire pfm_pkg::pfm_pins_t    pins_in,
    output pfm_pkg::pfm_drv_t          grp_a_pins,
    output pfm_pkg::pfm_drv_t          grp_b_pins,
    output pfm_pkg::pfm_drv_t          serial_grp_pins,
    output pfm_pkg::pfm_drv_t          key_grp_pins,
    output pfm_pkg::pfm_drv_t          timer_irq_grp_pins,
    output pfm_pkg::pfm_drv_t          lcd_shared_grp_pins,
    input  wire logic                  sio_sck_out,
    input  wire logic                  sio_data_out,
    input  wire logic                  timer_out,
    input  wire logic [5:0]            lcd_seg_shared_outs,
    output logic                       serial_clk_pin_in,
    output logic                       serial_in_pin_in,
    output logic                       irq
);
    import pfm_pkg::*;

    pfm_cfg_t   cfg_reg;
    pfm_cfg_t   cfg_next;
    pfm_pins_t  smp_reg;
    pfm_pins_t  prev_reg;
    pfm_drv_t   a_reg, b_reg, s_reg, k_reg, t_reg, l_reg;
    pfm_drv_t   a_next, b_next, s_next, k_next, t_next, l_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic       irq_reg;
    logic       sck_in_reg;
    logic       si_in_reg;
    logic [1:0] evt;
    logic [1:0] clr;
    logic       int_rise;
    logic       int_fall;
    logic [3:0] key_fall;
    pfm_pins_t  rd_val;

    // Configuration registers
    always_comb begin
        cfg_next = cfg_reg;
        if (bus.wr) begin
            case (bus.addr)
                `PFM_OFS_DAT_A:   cfg_next.lat.a = bus.wdata[3:0];
                `PFM_OFS_DAT_B:   cfg_next.lat.b = bus.wdata[1:0];
                `PFM_OFS_DAT_S:   cfg_next.lat.s = bus.wdata[2:0];
                `PFM_OFS_DAT_K:   cfg_next.lat.k = bus.wdata[3:0];
                `PFM_OFS_DAT_T:   cfg_next.lat.t = bus.wdata[1:0];
                `PFM_OFS_DAT_L:   cfg_next.lat.l = bus.wdata[5:0];
                `PFM_OFS_DIR_A:   cfg_next.dir.a = bus.wdata[3:0]; // R1
                `PFM_OFS_DIR_B:   cfg_next.dir.b = bus.wdata[1:0]; // R2
                `PFM_OFS_DIR_S:   cfg_next.dir.s = bus.wdata[2:0]; // R4
                `PFM_OFS_DIR_K:   cfg_next.dir.k = bus.wdata[3:0]; // R7
                `PFM_OFS_DIR_T:   cfg_next.dir.t = bus.wdata[1:0]; // R9
                `PFM_OFS_DIR_L:   cfg_next.dir.l = bus.wdata[5:0]; // R13
                `PFM_OFS_PU_SH:   cfg_next.pu_sh = bus.wdata & 8'h13;
                `PFM_OFS_PU_SER:  cfg_next.pu_ser = bus.wdata[2:0];
                `PFM_OFS_KRM:     cfg_next.krm = bus.wdata[0];
                `PFM_OFS_LCD_SEL: cfg_next.lcd_sel = bus.wdata[5:0]; // R12
                `PFM_OFS_SER_CTL: cfg_next.ser_ctl = bus.wdata[2:0]; // R5
                `PFM_OFS_KEY_CTL: cfg_next.key_ctl = bus.wdata[3:0]; // R8
                `PFM_OFS_TMR_CTL: cfg_next.tmr_ctl = bus.wdata[1:0]; // R10
                `PFM_OFS_EDGE:    cfg_next.edge_sel = bus.wdata[1:0]; // R11
                `PFM_OFS_IEN:     cfg_next.ien = bus.wdata[1:0];
                default:          cfg_next = cfg_reg;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg     <= '0; // R14
            cfg_reg.dir <= {$bits(pfm_pins_t){1'b1}}; // R16
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Pin sampling; pins are taken as synchronous, one stage for read and edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_reg  <= '0;
            prev_reg <= '0;
        end else begin
            smp_reg  <= pins_in;
            prev_reg <= smp_reg;
        end
    end

    // Pin drive, registered so every pin output comes from a flop
    // Unused upper slots of each drive word stay low so they never drive
    always_comb begin
        a_next     = '0;
        a_next.out = 8'(cfg_reg.lat.a);
        a_next.oe  = {4'h0, ~cfg_reg.dir.a}; // R1
        a_next.pu  = 8'({4{cfg_reg.pu_sh[`PFM_PU_SH_A]}} & cfg_reg.dir.a); // R3
        b_next     = '0;
        b_next.out = 8'(cfg_reg.lat.b);
        b_next.oe  = {6'h00, ~cfg_reg.dir.b}; // R2
        b_next.pu  = 8'({2{cfg_reg.pu_sh[`PFM_PU_SH_B]}} & cfg_reg.dir.b); // R3
        // Function output gated by latch, so software must set the latch to 1
        s_next     = '0;
        s_next.out = 8'((cfg_reg.ser_ctl & {cfg_reg.lat.s[2],
                                            sio_data_out & cfg_reg.lat.s[1],
                                            sio_sck_out & cfg_reg.lat.s[0]})
                        | (~cfg_reg.ser_ctl & cfg_reg.lat.s)); // R5 R6
        s_next.oe  = {5'h00, ~cfg_reg.dir.s}; // R6
        s_next.pu  = 8'(cfg_reg.pu_ser & cfg_reg.dir.s); // R4
        k_next     = '0;
        k_next.out = 8'(cfg_reg.lat.k);
        k_next.oe  = {4'h0, ~cfg_reg.dir.k};
        k_next.pu  = 8'({4{cfg_reg.pu_sh[`PFM_PU_SH_K] | cfg_reg.krm}}
                        & cfg_reg.dir.k); // R7
        t_next     = '0;
        t_next.out = 8'({cfg_reg.lat.t[1],
                         cfg_reg.tmr_ctl[0] ? timer_out : cfg_reg.lat.t[0]}); // R10
        t_next.oe  = {6'h00, ~cfg_reg.dir.t}; // R9
        l_next     = '0;
        l_next.out = 8'((cfg_reg.lcd_sel & lcd_seg_shared_outs)
                        | (~cfg_reg.lcd_sel & cfg_reg.lat.l)); // R12
        l_next.oe  = {2'h0, cfg_reg.lcd_sel | ~cfg_reg.dir.l}; // R13
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_reg <= '0; // R16
            b_reg <= '0;
            s_reg <= '0;
            k_reg <= '0;
            t_reg <= '0;
            l_reg <= '0;
        end else begin
            a_reg <= a_next;
            b_reg <= b_next;
            s_reg <= s_next;
            k_reg <= k_next;
            t_reg <= t_next;
            l_reg <= l_next;
        end
    end

    // Events: interrupt edge and key-return falling edge
    assign int_rise = smp_reg.t[1] & ~prev_reg.t[1];
    assign int_fall = ~smp_reg.t[1] & prev_reg.t[1];
    assign key_fall = prev_reg.k & ~smp_reg.k & cfg_reg.key_ctl & cfg_reg.dir.k; // R8
    assign evt[`PFM_EVT_INT] = cfg_reg.tmr_ctl[1] & cfg_reg.dir.t[1]
                               & ((cfg_reg.edge_sel[`PFM_EDGE_RISE] & int_rise)
                                  | (cfg_reg.edge_sel[`PFM_EDGE_FALL] & int_fall)); // R11
    assign evt[`PFM_EVT_KEY] = |key_fall;
    assign clr = (bus.wr && bus.addr == `PFM_OFS_ICLR) ? bus.wdata[1:0] : 2'h0;

    // Read value: input pins show sampled level, outputs show latch
    assign rd_val = (cfg_reg.lat & ~cfg_reg.dir) | (smp_reg & cfg_reg.dir); // R17

    always_comb begin
        // A new event wins over a clear in the same cycle
        stat_next  = (stat_reg & ~clr) | evt;
        rdata_next = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `PFM_OFS_DAT_A:   rdata_next = 8'(rd_val.a);
                `PFM_OFS_DAT_B:   rdata_next = 8'(rd_val.b);
                `PFM_OFS_DAT_S:   rdata_next = 8'(rd_val.s);
                `PFM_OFS_DAT_K:   rdata_next = 8'(rd_val.k);
                `PFM_OFS_DAT_T:   rdata_next = 8'(rd_val.t);
                `PFM_OFS_DAT_L:   rdata_next = 8'(rd_val.l);
                `PFM_OFS_DIR_A:   rdata_next = 8'(cfg_reg.dir.a);
                `PFM_OFS_DIR_B:   rdata_next = 8'(cfg_reg.dir.b);
                `PFM_OFS_DIR_S:   rdata_next = 8'(cfg_reg.dir.s);
                `PFM_OFS_DIR_K:   rdata_next = 8'(cfg_reg.dir.k);
                `PFM_OFS_DIR_T:   rdata_next = 8'(cfg_reg.dir.t);
                `PFM_OFS_DIR_L:   rdata_next = 8'(cfg_reg.dir.l);
                `PFM_OFS_PU_SH:   rdata_next = cfg_reg.pu_sh;
                `PFM_OFS_PU_SER:  rdata_next = 8'(cfg_reg.pu_ser);
                `PFM_OFS_KRM:     rdata_next = 8'(cfg_reg.krm);
                `PFM_OFS_LCD_SEL: rdata_next = 8'(cfg_reg.lcd_sel);
                `PFM_OFS_SER_CTL: rdata_next = 8'(cfg_reg.ser_ctl);
                `PFM_OFS_KEY_CTL: rdata_next = 8'(cfg_reg.key_ctl);
                `PFM_OFS_TMR_CTL: rdata_next = 8'(cfg_reg.tmr_ctl);
                `PFM_OFS_EDGE:    rdata_next = 8'(cfg_reg.edge_sel);
                `PFM_OFS_STAT:    rdata_next = 8'(stat_reg);
                `PFM_OFS_IEN:     rdata_next = 8'(cfg_reg.ien);
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg   <= 2'h0;
            rdata_reg  <= `PFM_RST_ZERO;
            irq_reg    <= 1'b0;
            sck_in_reg <= 1'b0;
            si_in_reg  <= 1'b0;
        end else begin
            stat_reg   <= stat_next;
            rdata_reg  <= rdata_next;
            irq_reg    <= |(stat_next & cfg_reg.ien);
            sck_in_reg <= cfg_reg.ser_ctl[0] & smp_reg.s[0]; // R5
            si_in_reg  <= cfg_reg.ser_ctl[2] & smp_reg.s[2]; // R5
        end
    end

    assign rdata               = rdata_reg;
    assign irq                 = irq_reg;
    assign serial_clk_pin_in   = sck_in_reg;
    assign serial_in_pin_in    = si_in_reg;
    assign grp_a_pins          = a_reg;
    assign grp_b_pins          = b_reg;
    assign serial_grp_pins     = s_reg;
    assign key_grp_pins        = k_reg;
    assign timer_irq_grp_pins  = t_reg;
    assign lcd_shared_grp_pins = l_reg;

    // Checks rest while reset is low
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_A_DIR: assert property (##1 grp_a_pins.oe[3:0] == ~$past(cfg_reg.dir.a)) // R1
        else $error("group A enable does not follow direction");
    AST_B_DIR: assert property (##1 grp_b_pins.oe[1:0] == ~$past(cfg_reg.dir.b)) // R2
        else $error("group B enable does not follow direction");
    AST_PU_IN_ONLY: assert property ((grp_a_pins.pu & grp_a_pins.oe) == 8'h00 // R3
                                     && (grp_b_pins.pu & grp_b_pins.oe) == 8'h00)
        else $error("pull-up on an output pin");
    AST_SER_PU: assert property (##1 serial_grp_pins.pu[2:0] // R4
                                 == $past(cfg_reg.pu_ser & cfg_reg.dir.s))
        else $error("serial pull-up wrong");
    AST_SER_SO: assert property (cfg_reg.ser_ctl[1] && !cfg_reg.dir.s[1] // R6
                                 |=> serial_grp_pins.out[1]
                                     == $past(sio_data_out & cfg_reg.lat.s[1]))
        else $error("serial data out not gated by latch");
    AST_KEY_PU: assert property (cfg_reg.krm && cfg_reg.dir.k[2] // R7
                                 |=> key_grp_pins.pu[2])
        else $error("key pull-up missing");
    AST_KEY_EVT: assert property (|key_fall |=> stat_reg[`PFM_EVT_KEY]) // R8
        else $error("key-return event lost");
    AST_TMR_OUT: assert property (cfg_reg.tmr_ctl[0] // R10
                                  |=> timer_irq_grp_pins.out[0] == $past(timer_out))
        else $error("timer output not routed");
    AST_EDGE_RISE: assert property (cfg_reg.tmr_ctl[1] && cfg_reg.dir.t[1] // R11
                                    && cfg_reg.edge_sel == 2'h1 && int_rise
                                    |=> stat_reg[`PFM_EVT_INT]
                                        && (irq || !$past(cfg_reg.ien[`PFM_EVT_INT])))
        else $error("rising edge not flagged");
    AST_LCD_OE: assert property (cfg_reg.lcd_sel[5] |=> lcd_shared_grp_pins.oe[5]) // R12
        else $error("LCD segment not driven");
    AST_RD_PORT: assert property (bus.rd && bus.addr == `PFM_OFS_DAT_A // R17
                                  |=> rdata == 8'($past(rd_val.a)))
        else $error("port read wrong");
    AST_RST_IN: assert property ($rose(rst_n) |-> cfg_reg.dir == '1 ##1 grp_a_pins.oe == 8'h00) // R16
        else $error("pin not input after reset");
    AST_T_DIR: assert property (##1 timer_irq_grp_pins.oe[1:0] == ~$past(cfg_reg.dir.t)) // R9
        else $error("timer group enable does not follow direction");
    AST_LCD_PORT_DIR: assert property (!cfg_reg.lcd_sel[0] // R13
        |=> lcd_shared_grp_pins.oe[0] != $past(cfg_reg.dir.l[0]))
        else $error("LCD pin in port mode ignores direction");
    AST_SCK_IN: assert property (cfg_reg.ser_ctl[0] // R5
        |=> serial_clk_pin_in == $past(smp_reg.s[0]))
        else $error("serial clock input not passed on");
    AST_SI_IN: assert property (cfg_reg.ser_ctl[2] // R5
        |=> serial_in_pin_in == $past(smp_reg.s[2]))
        else $error("serial data input not passed on");
    AST_UPPER_ZERO: assert property (grp_a_pins.oe[7:4] == 4'h0 // R1
                                     && lcd_shared_grp_pins.oe[7:6] == 2'h0)
        else $error("unused pin enable bit set");
    AST_STAT_SET: assert property (|evt |=> (stat_reg & $past(evt)) == $past(evt)) // R8
        else $error("event lost against clear");
    AST_DAT_LATCH: assert property (!cfg_reg.dir.a[0] // R17
                                    |=> grp_a_pins.out[0] == $past(cfg_reg.lat.a[0]))
        else $error("output pin does not drive its latch");
    AST_TMR_PORT: assert property (!cfg_reg.tmr_ctl[0] // R10
                                   |=> timer_irq_grp_pins.out[0] == $past(cfg_reg.lat.t[0]))
        else $error("timer pin in port mode does not drive its latch");
    AST_IRQ_LEVEL: assert property (##1 irq == |(stat_reg & $past(cfg_reg.ien))) // R11
        else $error("interrupt level does not follow enabled status");

    COV_INT: cover property (evt[`PFM_EVT_INT] ##1 irq);
    COV_KEY: cover property (evt[`PFM_EVT_KEY] ##1 stat_reg[`PFM_EVT_KEY]);
    COV_LCD: cover property (cfg_reg.lcd_sel != 6'h00 ##1 lcd_shared_grp_pins.oe != 8'h00);
    COV_SER: cover property (cfg_reg.ser_ctl == 3'h7 && cfg_reg.dir.s == 3'h4);
endmodule

// file: pfm_board.sv
`timescale 1ns/1ps
module pfm_board (
    input  wire logic               core_clk,
    input  wire pfm_pkg::pfm_drv_t  drv [6],
    input  wire logic [20:0]        ext_en,
    input  wire logic [20:0]        ext_val,
    output pfm_pkg::pfm_pins_t      pins
);
    import pfm_pkg::*;
    logic [20:0] oe_w;
    logic [20:0] out_w;
    logic [20:0] pu_w;
    logic [20:0] float_reg = '0;
    // External main clock source: clock and its inverse
    logic        main_osc_in;
    logic        main_osc_inv;
    assign main_osc_in  = core_clk;
    assign main_osc_inv = ~main_osc_in;
    assign oe_w  = {drv[0].oe[3:0], drv[1].oe[1:0], drv[2].oe[2:0],
                    drv[3].oe[3:0], drv[4].oe[1:0], drv[5].oe[5:0]};
    assign out_w = {drv[0].out[3:0], drv[1].out[1:0], drv[2].out[2:0],
                    drv[3].out[3:0], drv[4].out[1:0], drv[5].out[5:0]};
    assign pu_w  = {drv[0].pu[3:0], drv[1].pu[1:0], drv[2].pu[2:0],
                    drv[3].pu[3:0], drv[4].pu[1:0], drv[5].pu[5:0]};
    // Undriven, unpulled pins flip every cycle so a stale value never looks valid
    always_ff @(posedge core_clk) begin
        float_reg <= ~pins;
    end
    assign pins = (oe_w & out_w) | (~oe_w & ext_en & ext_val)
                | (~oe_w & ~ext_en & (pu_w | float_reg));
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "pfm_map.svh"
module testbench;
    import pfm_pkg::*;
    logic         core_clk = 1'b0;
    logic         rst_n = 1'b0;
    pfm_bus_req_t bus = '0;
    logic [7:0]   rdata;
    pfm_pins_t    pins;
    pfm_drv_t     drv [6];
    logic [20:0]  ext_en = '0;
    logic [20:0]  ext_val = '0;
    logic         sio_data_out = 1'b0;
    logic         sio_sck_out = 1'b0;
    logic         timer_out = 1'b0;
    logic [5:0]   seg = '0;
    logic         ser_clk_in;
    logic         ser_in;
    logic         irq;
    logic [7:0]   got;
    int           miscompares = 0;
    int           n_compared = 0;
    logic [23:0]  rows [11] = '{
        {`PFM_OFS_DIR_B, 16'h0101}, {`PFM_OFS_DIR_S, 16'h0505},
        {`PFM_OFS_DIR_T, 16'h0202}, {`PFM_OFS_DIR_L, 16'h0000},
        {`PFM_OFS_PU_SER, 16'h0404}, {`PFM_OFS_LCD_SEL, 16'h3030},
        {`PFM_OFS_EDGE, 16'h0101}, {`PFM_OFS_STAT, 16'hff00},
        {`PFM_OFS_ICLR, 16'h0300}, {8'h7f, 16'haa00},
        {`PFM_OFS_DIR_A, 16'hff0f}};

    always #5 core_clk = ~core_clk;

    pfm_port_mux dut (
        .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .pins_in(pins),
        .grp_a_pins(drv[0]), .grp_b_pins(drv[1]), .serial_grp_pins(drv[2]),
        .key_grp_pins(drv[3]), .timer_irq_grp_pins(drv[4]), .lcd_shared_grp_pins(drv[5]),
        .sio_sck_out(sio_sck_out), .sio_data_out(sio_data_out), .timer_out(timer_out),
        .lcd_seg_shared_outs(seg), .serial_clk_pin_in(ser_clk_in),
        .serial_in_pin_in(ser_in), .irq(irq));

    pfm_board board (.core_clk(core_clk), .drv(drv), .ext_en(ext_en),
        .ext_val(ext_val), .pins(pins));

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t bit got %b exp %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        #1 d = rdata;
    endtask
    task automatic ext(input logic [20:0] en, input logic [20:0] v);
        @(posedge core_clk);
        ext_en <= en;
        ext_val <= v;
    endtask
    // Pins follow config two edges after a write; status and irq two more
    task automatic settle;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic idle_check;
        for (int i = 0; i < 6; i++) begin
            chk8(drv[i].oe, 8'h00);
            chk8(drv[i].pu, 8'h00);
        end
        chk1(irq, 1'b0);
    endtask
    task automatic stop_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #1000000;
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        #1 idle_check();
        @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`PFM_OFS_DIR_A, got);
        chk8(got, 8'h0f);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], got);
            chk8(got, rows[i][7:0]);
        end
        $display("test registers done");
        ext(21'h1c0000, 21'h140000);
        wr(`PFM_OFS_DIR_A, 8'h0e);
        wr(`PFM_OFS_DAT_A, 8'h05);
        wr(`PFM_OFS_PU_SH, 8'h01);
        settle();
        chk8(drv[0].oe, 8'h01);
        chk1(drv[0].out[0], 1'b1);
        chk8(drv[0].pu, 8'h0e);
        chk8(drv[1].oe, 8'h02);
        chk8(drv[1].pu, 8'h00);
        rd(`PFM_OFS_DAT_A, got);
        chk8(got, 8'h0b);
        wr(`PFM_OFS_KRM, 8'h01);
        wr(`PFM_OFS_DIR_K, 8'h0c);
        settle();
        chk8(drv[3].pu, 8'h0c);
        chk8(drv[3].oe, 8'h03);
        wr(`PFM_OFS_KRM, 8'h00);
        wr(`PFM_OFS_PU_SH, 8'h10);
        settle();
        chk8(drv[3].pu, 8'h0c);
        wr(`PFM_OFS_PU_SH, 8'h00);
        settle();
        chk8(drv[3].pu, 8'h00);
        $display("test pullups done");
        ext(21'h005000, 21'h005000);
        wr(`PFM_OFS_SER_CTL, 8'h07);
        wr(`PFM_OFS_DAT_S, 8'h02);
        sio_data_out <= 1'b1;
        settle();
        chk8(drv[2].pu, 8'h04);
        chk8(drv[2].oe, 8'h02);
        chk1(drv[2].out[1], 1'b1);
        chk1(ser_clk_in, 1'b1);
        chk1(ser_in, 1'b1);
        @(posedge core_clk);
        sio_data_out <= 1'b0;
        settle();
        chk1(drv[2].out[1], 1'b0);
        wr(`PFM_OFS_DAT_S, 8'h00);
        sio_data_out <= 1'b1;
        settle();
        chk1(drv[2].out[1], 1'b0);
        wr(`PFM_OFS_DIR_S, 8'h04);
        wr(`PFM_OFS_DAT_S, 8'h01);
        sio_sck_out <= 1'b1;
        settle();
        chk1(drv[2].out[0], 1'b1);
        chk8(drv[2].oe, 8'h03);
        $display("test serial done");
        wr(`PFM_OFS_TMR_CTL, 8'h03);
        wr(`PFM_OFS_DAT_T, 8'h01);
        for (int v = 0; v < 2; v++) begin
            @(posedge core_clk);
            timer_out <= v[0];
            settle();
            chk1(drv[4].out[0], v[0]);
            chk8(drv[4].oe, 8'h01);
        end
        $display("test timer done");
        wr(`PFM_OFS_IEN, 8'h01);
        for (int m = 1; m < 5; m++) begin
            if (m == 4)
                wr(`PFM_OFS_IEN, 8'h00);
            wr(`PFM_OFS_EDGE, (m == 4) ? 8'h01 : m[7:0]);
            ext(21'h000080, 21'h000000);
            settle();
            wr(`PFM_OFS_ICLR, 8'h03);
            ext(21'h000080, 21'h000080);
            settle();
            rd(`PFM_OFS_STAT, got);
            chk8(got, {7'h00, m[0] | m[2]});
            chk1(irq, m[0]);
            wr(`PFM_OFS_ICLR, 8'h03);
            ext(21'h000080, 21'h000000);
            settle();
            rd(`PFM_OFS_STAT, got);
            chk8(got, {7'h00, m[1]});
        end
        $display("test interrupt done");
        wr(`PFM_OFS_DIR_K, 8'h0f);
        wr(`PFM_OFS_KEY_CTL, 8'h0f);
        ext(21'h000f80, 21'h000f00);
        settle();
        wr(`PFM_OFS_ICLR, 8'h03);
        ext(21'h000f80, 21'h000b00);
        settle();
        rd(`PFM_OFS_STAT, got);
        chk8(got, 8'h02);
        $display("test key done");
        wr(`PFM_OFS_DAT_L, 8'h05);
        seg <= 6'h2a;
        settle();
        chk8(drv[5].oe, 8'h3f);
        chk8(drv[5].out, 8'h25);
        wr(`PFM_OFS_DIR_L, 8'h0f);
        settle();
        chk8(drv[5].oe, 8'h30);
        $display("test lcd done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 idle_check();
        @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`PFM_OFS_LCD_SEL, got);
        chk8(got, 8'h00);
        rd(`PFM_OFS_DIR_T, got);
        chk8(got, 8'h03);
        $display("test second reset done");
        stop_test();
    end
endmodule
